/* lbus_arb_regs.vh */
/*
 * Constants for the logical bus arbitration block: state codes,
 * search resume tracking codes, synchroniser depth.
 * Assumes inclusion by bare name from the design files.
 */
// How it works
// - request bus on translation cache miss
// - request bus on first write to unmodified page
// - request bus on module call, descriptor absent
// - request bus for coprocessor table search instruction
// - request, grant, then acknowledge or pass grant
// - watch alternate request input, drive own request
// - alternate request means higher priority master
// - searching adopts served master priority
// - abort after bus cycle, then drop acknowledge
// - withdraw request when preempted before grant
// - wait strobe negate, drop bus error, then request
// - answer status query with relinquish and retry
// - relinquish and retry gains bus, query repeats
// - resume aborted search if no other search
// - otherwise discard saved state and restart
// - acknowledge only under all bus free conditions
// - pass grant at once when idle and not in early startup mode
`ifndef LBUS_ARB_REGS_VH
`define LBUS_ARB_REGS_VH

// ----------------------------------------------------------------
// synchroniser
// ----------------------------------------------------------------
`define SYNC_STAGES 2

// ----------------------------------------------------------------
// arbiter states, one-hot
// ----------------------------------------------------------------
`define ST_W        6
`define ST_IDLE     6'h01
`define ST_REQ      6'h02
`define ST_OWN      6'h04
`define ST_ABORT    6'h08
`define ST_WAITLAS  6'h10
`define ST_DROP     6'h20

// ----------------------------------------------------------------
// search resume tracking, one-hot
// ----------------------------------------------------------------
`define RS_W        3
`define RS_NONE     3'h1
`define RS_SAVED    3'h2
`define RS_STALE    3'h4

`endif

/* sync_bit.v */
/*
 * Multi-stage level synchroniser for one input bit.
 * Assumes a single clock and synchronous active-high reset.
 */
`timescale 1ns/1ps
module sync_bit #(
	parameter STAGES = 2
) (
	input  wire core_clk_i,  // system clock
	input  wire sys_rst_i,   // sync reset
	input  wire d_i,         // async level
	output wire q_o          // synchronised level
);
	reg [STAGES-1:0] chain_reg;

	// shift chain; only the next stage reads each flop
	always @(posedge core_clk_i) begin
		if (sys_rst_i)
			chain_reg <= {STAGES{1'b0}};
		else
			chain_reg <= {chain_reg[STAGES-2:0], d_i};
	end

	assign q_o = chain_reg[STAGES-1];
endmodule

/* search_ctx.v */
/*
 * Saved table-search context: holds the interruption point of an
 * aborted search and reports whether it can be resumed.
 * Assumes save, other-search and clear strobes from the arbiter.
 */
`timescale 1ns/1ps
`include "lbus_arb_regs.vh"
module search_ctx #(
	parameter PW = 8
) (
	input  wire          core_clk_i,   // system clock
	input  wire          sys_rst_i,    // sync reset
	input  wire          save_i,       // abort: keep point
	input  wire [PW-1:0] point_i,      // search progress point
	input  wire          other_i,      // unrelated search ran
	input  wire          clear_i,      // search completed
	output reg  [PW-1:0] point_o,      // resume point
	output reg           valid_o,      // context pending
	output reg           resume_o      // resume, not restart
);
	reg [`RS_W-1:0] st_reg;
	reg [`RS_W-1:0] st_next;

	// resume tracking; a save in the same cycle wins
	always @* begin
		st_next = st_reg;
		if (save_i)
			st_next = `RS_SAVED;
		else if (clear_i)
			st_next = `RS_NONE;
		else if (other_i && st_reg == `RS_SAVED)
			st_next = `RS_STALE;
	end

	// registered context and outputs
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_reg   <= `RS_NONE;
			point_o  <= {PW{1'b0}};
			valid_o  <= 1'b0;
			resume_o <= 1'b0;
		end else begin
			st_reg   <= st_next;
			if (save_i)
				point_o <= point_i;
			valid_o  <= (st_next != `RS_NONE);
			resume_o <= (st_next == `RS_SAVED);
		end
	end
endmodule

/* lbus_arb.v */
/*
 * Logical bus arbitration for the translation unit: raises its own
 * request on a search need, acknowledges or passes grants, aborts
 * and backs off when a higher priority master asks, and tracks
 * whether an aborted search resumes or restarts.
 * Assumes outside logic ORs own_bus_req_out with alt_master_req_in,
 * never loops it back, and conditions alternate masters.
 * Strobes and acknowledges here are active-high internal levels.
 */
`timescale 1ns/1ps
`include "lbus_arb_regs.vh"
module lbus_arb #(
	parameter PW = 8
) (
	input  wire          core_clk_i,        // system clock
	input  wire          sys_rst_i,         // sync reset
	// search causes
	input  wire          atc_miss_i,        // no descriptor cached
	input  wire          write_i,           // master write cycle
	input  wire          rmw_i,             // read-modify-write
	input  wire          page_unmod_i,      // page not modified
	input  wire          modcall_miss_i,    // module call miss
	input  wire          cop_search_i,      // coprocessor search
	input  wire          early_start_i,     // early startup mode
	// arbitration pins
	input  wire          alt_master_req_in_i,   // higher prio req
	input  wire          grant_in_i,            // arbiter grant
	input  wire          grant_ack_in_i,        // other master ack
	input  wire          logical_address_strobe_i, // master strobe
	input  wire          data_size_acknowledge_i,  // slave ack
	output reg           own_bus_req_out_o,     // own request
	output reg           grant_pass_out_o,      // passed grant
	output reg           grant_acknowledge_o,   // mastership
	output reg           grant_acknowledge_oe_o,// drive enable
	output reg           bus_error_n_o,         // bus error, low
	output reg           bus_error_n_oe_o,      // drive enable
	output reg           halt_n_o,              // halt, low
	// search engine
	input  wire          cycle_busy_i,      // own cycle running
	input  wire          search_done_i,     // search finished
	input  wire [PW-1:0] search_point_i,    // progress point
	input  wire          status_query_i,    // response reg read
	output reg           search_go_o,       // run search
	output reg           search_resume_o,   // continue, not restart
	output reg  [PW-1:0] resume_point_o,    // point to continue
	output reg           retry_answer_o     // relinquish and retry
);
	// ----------------------------------------------------------------
	// synchronised inputs
	// ----------------------------------------------------------------
	wire alt_req_s;
	wire grant_s;

	// both inputs cross into the core clock first
	sync_bit #(.STAGES(`SYNC_STAGES)) u_sync_req (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.d_i        (alt_master_req_in_i),
		.q_o        (alt_req_s)
	);
	sync_bit #(.STAGES(`SYNC_STAGES)) u_sync_gnt (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.d_i        (grant_in_i),
		.q_o        (grant_s)
	);

	// ----------------------------------------------------------------
	// search need decode
	// ----------------------------------------------------------------
	function need_fn;
		input miss;
		input wr;
		input rmw;
		input unmod;
		input mc;
		input cop;
		begin
			need_fn = miss | (wr & ~rmw & unmod) | mc | cop;
		end
	endfunction

	wire need_w = need_fn(atc_miss_i, write_i, rmw_i, page_unmod_i,
		modcall_miss_i, cop_search_i);

	// ----------------------------------------------------------------
	// saved search context
	// ----------------------------------------------------------------
	reg  save_reg;
	reg  other_reg;
	reg  clear_reg;
	reg  pend_reg;
	wire ctx_valid;
	wire ctx_resume;
	wire [PW-1:0] ctx_point;

	search_ctx #(.PW(PW)) u_ctx (
		.core_clk_i (core_clk_i),
		.sys_rst_i  (sys_rst_i),
		.save_i     (save_reg),
		.point_i    (search_point_i),
		.other_i    (other_reg),
		.clear_i    (clear_reg),
		.point_o    (ctx_point),
		.valid_o    (ctx_valid),
		.resume_o   (ctx_resume)
	);

	// ----------------------------------------------------------------
	// arbitration state machine
	// ----------------------------------------------------------------
	reg [`ST_W-1:0] st_reg;
	reg [`ST_W-1:0] st_next;
	reg             retry_flag_reg;
	reg             asked_reg;

	// bus free test for taking mastership
	wire bus_free = ~alt_req_s & ~logical_address_strobe_i &
		~data_size_acknowledge_i & ~grant_ack_in_i;

	// next state
	always @* begin
		st_next = st_reg;
		case (st_reg)
		`ST_IDLE: begin
			if (need_w)
				st_next = `ST_REQ;
		end
		`ST_REQ: begin
			if (alt_req_s)
				st_next = `ST_WAITLAS;
			else if (grant_s && bus_free)
				st_next = `ST_OWN;
		end
		`ST_OWN: begin
			if (alt_req_s)
				st_next = `ST_ABORT;
			else if (search_done_i)
				st_next = `ST_IDLE;
		end
		`ST_ABORT: begin
			if (!cycle_busy_i)
				st_next = `ST_IDLE;
		end
		`ST_WAITLAS: begin
			if (!logical_address_strobe_i)
				st_next = `ST_DROP;
		end
		`ST_DROP:
			st_next = `ST_IDLE;
		default:
			st_next = `ST_IDLE;
		endcase
	end

	// state, outputs and context strobes
	always @(posedge core_clk_i) begin
		if (sys_rst_i) begin
			st_reg                 <= `ST_IDLE;
			own_bus_req_out_o      <= 1'b0;
			grant_pass_out_o       <= 1'b0;
			grant_acknowledge_o    <= 1'b0;
			grant_acknowledge_oe_o <= 1'b0;
			bus_error_n_o          <= 1'b1;
			bus_error_n_oe_o       <= 1'b0;
			halt_n_o               <= 1'b1;
			search_go_o            <= 1'b0;
			search_resume_o        <= 1'b0;
			resume_point_o         <= {PW{1'b0}};
			retry_answer_o         <= 1'b0;
			retry_flag_reg         <= 1'b0;
			asked_reg              <= 1'b0;
			save_reg               <= 1'b0;
			other_reg              <= 1'b0;
			clear_reg              <= 1'b0;
			pend_reg               <= 1'b0;
		end else begin
			st_reg <= st_next;
			// request held from need until ack or withdrawal
			own_bus_req_out_o <= (st_next == `ST_REQ) ||
				(st_next == `ST_WAITLAS) ||
				(st_next == `ST_DROP);
			// own ack while holding the bus, through abort
			grant_acknowledge_o <= (st_next == `ST_OWN) ||
				(st_next == `ST_ABORT);
			grant_acknowledge_oe_o <= (st_next == `ST_OWN) ||
				(st_next == `ST_ABORT);
			// pass grant when idle outside early startup mode, or while aborting
			grant_pass_out_o <= grant_s & alt_req_s &
				(((st_reg == `ST_IDLE) & ~early_start_i) |
				(st_reg == `ST_ABORT));
			// bus error of retry held until strobe negates
			bus_error_n_o    <= ~(st_next == `ST_WAITLAS);
			bus_error_n_oe_o <= (st_next == `ST_WAITLAS);
			// halt drops with bus error, releases one cycle after it
			halt_n_o <= ~((st_next == `ST_WAITLAS) ||
				(st_next == `ST_DROP));
			search_go_o <= (st_next == `ST_OWN);
			// abort keeps context; other searches mark stale
			save_reg  <= (st_reg == `ST_OWN) & alt_req_s;
			clear_reg <= (st_reg == `ST_OWN) & search_done_i;
			other_reg <= (st_reg == `ST_IDLE) & need_w &
				ctx_valid & ~asked_reg;
			pend_reg  <= ctx_valid;
			search_resume_o <= ctx_resume;
			resume_point_o  <= ctx_point;
			// relinquish interrupted: query answered with retry
			if (st_reg == `ST_WAITLAS || save_reg)
				retry_flag_reg <= 1'b1;
			else if (st_reg == `ST_OWN && search_done_i)
				retry_flag_reg <= 1'b0;
			// query seen since abort: next need is the same search
			if (save_reg)
				asked_reg <= 1'b0;
			else if (status_query_i && pend_reg)
				asked_reg <= 1'b1;
			retry_answer_o <= status_query_i &
				(retry_flag_reg | pend_reg);
		end
	end
endmodule

/* lbus_arb_chk.sv */
/* port checker for the logical bus arbitration block.
   assumes one clock domain and the bind below. */
`timescale 1ns/1ps
module lbus_arb_chk (
	input wire logic core_clk_i,               // clock
	input wire logic sys_rst_i,                // reset
	input wire logic atc_miss_i,               // cache miss
	input wire logic write_i,                  // write
	input wire logic rmw_i,                    // locked cycle
	input wire logic page_unmod_i,             // clean page
	input wire logic modcall_miss_i,           // module call
	input wire logic cop_search_i,             // coprocessor
	input wire logic grant_in_i,               // grant
	input wire logic grant_ack_in_i,           // other ack
	input wire logic logical_address_strobe_i, // strobe
	input wire logic data_size_acknowledge_i,  // slave ack
	input wire logic cycle_busy_i,             // own cycle
	input wire logic status_query_i,           // query
	input wire logic own_bus_req_out_o,        // request
	input wire logic grant_pass_out_o,         // passed grant
	input wire logic grant_acknowledge_o,      // mastership
	input wire logic bus_error_n_o,            // bus error
	input wire logic search_go_o,              // searching
	input wire logic search_resume_o,          // resume
	input wire logic retry_answer_o            // retry answer
);
	default clocking cb @(posedge core_clk_i); endclocking
	default disable iff (sys_rst_i);
	// search need and bus occupancy seen by the block
	wire need = atc_miss_i | (write_i & ~rmw_i & page_unmod_i) |
		modcall_miss_i | cop_search_i;
	wire bus_used = logical_address_strobe_i | data_size_acknowledge_i |
		grant_ack_in_i;
	chk_req_cause: assert property (
		$rose(own_bus_req_out_o) |-> $past(need)) else $error("req no cause");
	chk_ack_grant: assert property (
		$rose(grant_acknowledge_o) |-> $past(grant_in_i, 3))
		else $error("ack without grant");
	chk_ack_free: assert property (
		$rose(grant_acknowledge_o) |-> !$past(bus_used))
		else $error("ack on busy bus");
	chk_abort_wait: assert property (
		$fell(grant_acknowledge_o) |-> !$past(cycle_busy_i))
		else $error("ack dropped in cycle");
	chk_pass_idle: assert property (
		$rose(grant_pass_out_o) |-> !own_bus_req_out_o)
		else $error("pass while requesting");
	chk_req_hold: assert property (
		$fell(own_bus_req_out_o) |-> grant_acknowledge_o || $past(bus_error_n_o))
		else $error("request dropped early");
	chk_bus_error_n_las: assert property (
		!bus_error_n_o && logical_address_strobe_i |=> !bus_error_n_o)
		else $error("bus error left early");
	chk_bus_error_n_first: assert property (
		$rose(bus_error_n_o) |=> !own_bus_req_out_o)
		else $error("request kept after error");
	chk_retry_query: assert property (
		retry_answer_o |-> $past(status_query_i)) else $error("stray retry");
	chk_go_owned: assert property (
		search_go_o |-> grant_acknowledge_o) else $error("search unowned");
	// main scenarios
	cover property ($rose(grant_acknowledge_o));
	cover property ($rose(grant_pass_out_o));
	cover property ($rose(bus_error_n_o));
	cover property (search_go_o && search_resume_o);
endmodule
bind lbus_arb lbus_arb_chk u_chk (.*);

/* lbus_partner.sv */
/* far side: logical bus arbiter fed by the ored requests.
   assumes the bench sets the grant delay. */
`timescale 1ns/1ps
module lbus_partner (
	input  wire logic       core_clk_i, // clock
	input  wire logic       sys_rst_i,  // reset
	input  wire logic       own_req_i,  // device request
	input  wire logic       alt_req_i,  // alternate request
	input  wire logic [4:0] dly_i,      // grant delay
	output logic            grant_o     // bus grant
);
	logic [4:0] wait_reg;
	// grant once the ored request has stood dly_i+1 cycles
	always @(posedge core_clk_i) begin
		if (sys_rst_i || !(own_req_i || alt_req_i)) begin
			wait_reg <= 5'h00;
			grant_o  <= 1'b0;
		end else if (wait_reg >= dly_i) begin
			grant_o <= 1'b1;
		end else begin
			wait_reg <= wait_reg + 5'h01;
		end
	end
endmodule

/* lbus_arb_test.sv */
/* self-checking bench for lbus_arb with the arbiter model.
   assumes the checker is bound by its own file. */
`timescale 1ns/1ps
module lbus_arb_test;
	logic       clk = 1'b0, rst = 1'b1, early = 1'b0, alt = 1'b0;
	logic       gack = 1'b0, logical_address_strobe = 1'b0, dsk = 1'b0, busy = 1'b0;
	logic       done = 1'b0, query = 1'b0, grant;
	logic [5:0] cause = 6'h00, c;
	logic [7:0] point = 8'h00, rpoint;
	logic [4:0] dly = 5'h02;
	logic       req, pass, ack, ack_oe, bus_error_n_n, bus_error_n_oe, halt_n, go, res, rty;
	logic [5:0] tbl [5] = '{6'h20, 6'h14, 6'h1C, 6'h02, 6'h01};
	int         num_errors = 0, total_checks = 0;
	int         saved_q [$];
	lbus_arb #(.PW(8)) DUT (.core_clk_i(clk), .sys_rst_i(rst),
		.atc_miss_i(cause[5]), .write_i(cause[4]), .rmw_i(cause[3]),
		.page_unmod_i(cause[2]), .modcall_miss_i(cause[1]),
		.cop_search_i(cause[0]), .early_start_i(early),
		.alt_master_req_in_i(alt), .grant_in_i(grant),
		.grant_ack_in_i(gack), .logical_address_strobe_i(logical_address_strobe),
		.data_size_acknowledge_i(dsk), .own_bus_req_out_o(req),
		.grant_pass_out_o(pass), .grant_acknowledge_o(ack),
		.grant_acknowledge_oe_o(ack_oe), .bus_error_n_o(bus_error_n_n),
		.bus_error_n_oe_o(bus_error_n_oe), .halt_n_o(halt_n),
		.cycle_busy_i(busy), .search_done_i(done),
		.search_point_i(point), .status_query_i(query),
		.search_go_o(go), .search_resume_o(res),
		.resume_point_o(rpoint), .retry_answer_o(rty));
	lbus_partner arb (.core_clk_i(clk), .sys_rst_i(rst), .own_req_i(req),
		.alt_req_i(alt), .dly_i(dly), .grant_o(grant));
	always #5 clk = ~clk;
	// --------------------------------------------------------------
	// helpers
	// --------------------------------------------------------------
	function automatic logic need_of(logic [5:0] v);
		return v[5] | (v[4] & ~v[3] & v[2]) | v[1] | v[0];
	endfunction
	task automatic chk(string nm, logic [7:0] e, logic [7:0] g);
		total_checks++;
		if (g !== e) begin
			num_errors++;
			$display("[ERR] %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic complete_run();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// bounded wait: 0 req, 1 ack, 2 pass
	task automatic wt(int s, logic v);
		for (int i = 0; i < 60; i++) begin
			@(posedge clk);
			#1;
			if ((s == 0 ? req : s == 1 ? ack : pass) === v)
				return;
		end
		num_errors++;
		$display("[ERR] wait %0d exp %b got other", s, v);
		complete_run();
	endtask
	task automatic start(logic [5:0] v);
		@(posedge clk);
		cause <= v;
		@(posedge clk);
		cause <= 6'h00;
	endtask
	task automatic serve(logic r);
		wt(1, 1'b1);
		chk("req", 0, req);
		chk("go", 1, go);
		chk("ack oe", 1, ack_oe);
		chk("resume", r, res);
		if (r)
			chk("point", saved_q.pop_front(), rpoint);
		@(posedge clk);
		done <= 1'b1;
		@(posedge clk);
		done <= 1'b0;
		wt(1, 1'b0);
	endtask
	task automatic abort_at(logic [7:0] p);
		@(posedge clk);
		point <= p;
		start(6'h01);
		wt(1, 1'b1);
		@(posedge clk);
		busy <= 1'b1;
		alt <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk("ack held", 1, ack);
		@(posedge clk);
		busy <= 1'b0;
		point <= 8'h33;
		wt(1, 1'b0);
		saved_q.push_back(p);
		@(posedge clk);
		alt <= 1'b0;
		wt(2, 1'b0);
	endtask
	// --------------------------------------------------------------
	// tests
	// --------------------------------------------------------------
	initial begin
		void'($urandom(8));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		// each cause raises the request
		for (int k = 0; k < 12; k++) begin
			c = (k < 5) ? tbl[k] : 6'($urandom);
			@(posedge clk);
			dly <= 5'($urandom % 6);
			start(c);
			#1 chk("req", {7'h00, need_of(c)}, req);
			if (need_of(c))
				serve(1'b0);
		end
		$display("test causes done");
		// a busy bus holds back mastership
		for (int b = 0; b < 3; b++) begin
			@(posedge clk);
			dly <= 5'h00;
			{gack, dsk, logical_address_strobe} <= 3'b001 << b;
			start(6'h20);
			repeat (8) @(posedge clk);
			#1 chk("ack blocked", 0, ack);
			@(posedge clk);
			{gack, dsk, logical_address_strobe} <= 3'b000;
			serve(1'b0);
		end
		$display("test blockers done");
		@(posedge clk);
		early <= 1'b1;
		alt <= 1'b1;
		repeat (10) @(posedge clk);
		#1 chk("pass early", 0, pass);
		@(posedge clk);
		early <= 1'b0;
		wt(2, 1'b1);
		chk("req", 0, req);
		@(posedge clk);
		alt <= 1'b0;
		wt(2, 1'b0);
		$display("test pass done");
		abort_at(8'h5A);
		@(posedge clk);
		query <= 1'b1;
		@(posedge clk);
		query <= 1'b0;
		#1 chk("retry", 1, rty);
		start(6'h01);
		serve(1'b1);
		$display("test resume done");
		abort_at(8'hA5);
		start(6'h20);
		serve(1'b0);
		void'(saved_q.pop_front());
		start(6'h01);
		serve(1'b0);
		$display("test restart done");
		@(posedge clk);
		dly <= 5'h14;
		logical_address_strobe <= 1'b1;
		start(6'h01);
		@(posedge clk);
		alt <= 1'b1;
		repeat (6) @(posedge clk);
		#1 chk("bus_error_n", 0, bus_error_n_n);
		chk("req kept", 1, req);
		chk("bus_error_n oe", 1, bus_error_n_oe);
		chk("halt", 0, halt_n);
		@(posedge clk);
		logical_address_strobe <= 1'b0;
		@(posedge clk);
		#1 chk("halt held", 0, halt_n);
		chk("req held", 1, req);
		wt(0, 1'b0);
		chk("bus_error_n off", 1, bus_error_n_n);
		chk("halt off", 1, halt_n);
		@(posedge clk);
		alt <= 1'b0;
		repeat (5) @(posedge clk);
		$display("test withdraw done");
		complete_run();
	end
endmodule
